// ==== include/tbs_pkg.sv ====
// Constants and carrier types for the token bus MAC status register bank.
// Assumes one clock domain; all MAC status inputs come from logic on aclk.
package tbs_pkg;
    localparam logic [7:0] TBS_ADDR_STATUS = 8'h00;
    localparam logic [7:0] TBS_ADDR_CTRL = 8'h04;
    localparam logic [7:0] TBS_ADDR_ACK = 8'h08;
    localparam int TBS_BIT_OFFLINE = 0;
    localparam int TBS_BIT_LISTEN = 2;
    localparam int TBS_BIT_NOT_HOLD = 3;
    localparam int TBS_BIT_HOLD = 4;
    localparam int TBS_BIT_REQ_EMPTY = 5;
    localparam int TBS_BIT_BUS_LOCK = 6;
    localparam int TBS_BIT_LIST_LOCK = 7;
    localparam int TBS_BIT_RX_ON = 8;
    localparam int TBS_BIT_FIFO_DIR = 9;
    localparam int TBS_BIT_LOCK_WINNER = 11;
    localparam int TBS_BIT_RING_POLL = 12;
    localparam int TBS_BIT_CONF_IND = 13;
    localparam int TBS_BIT_RX_OVERRUN = 14;
    localparam int TBS_BIT_FIFO_FAULT = 15;
    localparam int TBS_BIT_BAD_LEN = 16;
    localparam int TBS_BIT_TIMER_ROLE = 17;
    localparam int TBS_BIT_BLOCK_PRIO = 18;
    localparam int TBS_BIT_IDLE_LO = 19;
    localparam int TBS_BIT_STATION_LO = 21;
    localparam int TBS_BIT_REV_LO = 24;
    localparam int TBS_BIT_ACK_FLAGS = 1;
    localparam int TBS_BIT_CTRL_LOCK = 0;
    localparam logic [31:0] TBS_STATUS_RESET = 32'h0000_0000;
    localparam logic TBS_LOCK_RESET = 1'b0;
    localparam logic [8:0] TBS_LEN_LIMIT = 9'h100;
    localparam logic [2:0] TBS_STN_PASSIVE = 3'h0;
    localparam logic [2:0] TBS_STN_READY = 3'h2;
    localparam logic [2:0] TBS_STN_ACTIVE = 3'h3;
    localparam logic [1:0] TBS_IDLE_SYNC = 2'h0;
    localparam logic [1:0] TBS_IDLE_READY = 2'h1;
    localparam logic [1:0] TBS_IDLE_FIRST = 2'h2;
    localparam logic [1:0] TBS_IDLE_SECOND = 2'h3;
    localparam logic [1:0] TBS_RESP_OKAY = 2'h0;
    localparam logic [1:0] TBS_RESP_DECERR = 2'h3;

    typedef struct packed {
        logic offline;
        logic listen_token;
        logic not_hold_token;
        logic hold_token;
        logic req_empty;
        logic bus_lock;
        logic receiver_on;
        logic fifo_direction;
        logic dual_port_mode;
        logic lock_conflict;
        logic local_lock_first;
        logic ring_poll_request_held;
        logic conf_ind_held;
        logic timer_role;
        logic current_block_priority;
        logic [1:0] idle_select;
        logic [2:0] station_kind;
    } tbs_mac_state_t;

    typedef struct packed {
        logic new_frame;
        logic transfer_busy;
        logic fifo_underrun;
        logic fifo_overrun;
        logic req_check;
        logic [7:0] header_len;
        logic [7:0] payload_len;
    } tbs_mac_event_t;
endpackage

// ==== verification/tbs_host_model.sv ====
// Behavioural AXI4-Lite host that reads and writes the status register bank.
// Assumes one access at a time; the bench watchdog ends a slave that never answers.
`timescale 1ns/1ns
module tbs_host_model
    import tbs_pkg::*;
(
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // Handshakes are judged at the falling edge, where every channel is settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_hs, w_hs, b_hs;
        b_hs = 1'b0;
        resp = 2'h2;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_hs)
        begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid && s_axi_bready;
            if (b_hs)
                resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs)
                s_axi_awvalid <= 1'b0;
            if (w_hs)
                s_axi_wvalid <= 1'b0;
            if (w_hs)
                s_axi_wdata <= ~d;
            if (b_hs)
                s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_hs, r_hs;
        r_hs = 1'b0;
        resp = 2'h2;
        d = 32'hDEAD_BEEF;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_hs)
        begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid && s_axi_rready;
            if (r_hs)
                d = s_axi_rdata;
            if (r_hs)
                resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs)
                s_axi_arvalid <= 1'b0;
            if (r_hs)
                s_axi_rready <= 1'b0;
        end
    endtask
endmodule

// ==== verification/tbs_tb.sv ====
// Self-checking bench for the status register bank: random MAC state, sticky events, lock.
// Assumes the host model as register master and MAC inputs driven here on aclk.
`timescale 1ns/1ns
module tb
    import tbs_pkg::*;
;
    localparam logic [7:0] REV = 8'h5C; // Arbitrary value
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, list_service_en, rx_active, tx_len_invalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, tx_payload_len;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    tbs_mac_state_t mac_state, st;
    tbs_mac_event_t mac_event;
    logic lk;
    int bad_count, n_compared;
    tbs_status_regs #(.ADDR_W(8), .REVISION(REV)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mac_state(mac_state), .mac_event(mac_event),
        .list_service_en(list_service_en), .rx_active(rx_active), .tx_len_invalid(tx_len_invalid),
        .tx_payload_len(tx_payload_len));
    tbs_host_model host (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    // Flags f are {bad_request_length, fifo_fault, rx_frame_overrun}
    function automatic logic [31:0] exp_status(input tbs_mac_state_t s, input logic l, input logic [2:0] f);
        logic lw;
        lw = s.dual_port_mode & s.lock_conflict & s.local_lock_first;
        return {REV, s.station_kind, s.idle_select, s.current_block_priority, s.timer_role, f, s.conf_ind_held,
            s.ring_poll_request_held, lw, 1'b0, s.fifo_direction, s.receiver_on, l, s.bus_lock, s.req_empty,
            s.hold_token, s.not_hold_token, s.listen_token, 1'b0, s.offline};
    endfunction
    function automatic tbs_mac_event_t mk_ev(input logic [4:0] k, input logic [7:0] h, input logic [7:0] p);
        return {k, h, p};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        host.rd(a, rd, rs);
        chk(rd, exp, "read data");
        chk({30'h0, rs}, {30'h0, er}, "read response");
    endtask
    // Event bits k are {new_frame, transfer_busy, fifo_underrun, fifo_overrun, req_check}
    task automatic step(input logic [4:0] k, input logic [7:0] h, input logic [7:0] p, input logic [2:0] f);
        @(posedge aclk);
        mac_event <= mk_ev(k, h, p);
        @(posedge aclk);
        mac_event <= mk_ev(k & 5'b01000, h, p);
        settle();
        rd_chk(TBS_ADDR_STATUS, exp_status(st, lk, f), TBS_RESP_OKAY);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial
    begin
        #100000;
        bad_count++;
        conclude();
    end
    initial
    begin
        logic [2:0] stn [3];
        logic [7:0] h, p;
        stn = '{TBS_STN_PASSIVE, TBS_STN_READY, TBS_STN_ACTIVE};
        void'($urandom(78411));
        aresetn = 1'b0;
        mac_state = '0;
        mac_event = '0;
        st = '0;
        lk = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk({31'h0, list_service_en}, 32'h1, "lists serviced after reset");
        rd_chk(TBS_ADDR_STATUS, exp_status(st, 1'b0, 3'h0), TBS_RESP_OKAY);
        $display("reset test done");
        for (int i = 0; i < 12; i++)
        begin
            st = tbs_mac_state_t'($urandom);
            st.idle_select = i[1:0];
            st.station_kind = stn[i % 3];
            if (i % 4 >= 2)
                {st.lock_conflict, st.local_lock_first} = 2'b11;
            if (i % 4 >= 2)
                st.dual_port_mode = (i % 4 == 2);
            @(posedge aclk);
            mac_state <= st;
            host.wr(TBS_ADDR_STATUS, $urandom, rs);
            chk({30'h0, rs}, {30'h0, TBS_RESP_OKAY}, "status write response");
            settle();
            chk({31'h0, rx_active}, {31'h0, st.fifo_direction & st.receiver_on}, "rx_active");
            rd_chk(TBS_ADDR_STATUS, exp_status(st, lk, 3'h0), TBS_RESP_OKAY);
        end
        $display("live status test done");
        for (int i = 1; i >= 0; i--)
        begin
            lk = i[0];
            host.wr(TBS_ADDR_CTRL, {31'h0, lk}, rs);
            settle();
            chk({31'h0, list_service_en}, {31'h0, ~lk}, "list service enable");
            rd_chk(TBS_ADDR_CTRL, {31'h0, lk}, TBS_RESP_OKAY);
            rd_chk(TBS_ADDR_STATUS, exp_status(st, lk, 3'h0), TBS_RESP_OKAY);
        end
        $display("lock test done");
        st.fifo_direction = 1'b0;
        @(posedge aclk);
        mac_state <= st;
        step(5'b10000, 8'h00, 8'h00, 3'b000);
        step(5'b11000, 8'h00, 8'h00, 3'b001);
        step(5'b00010, 8'h00, 8'h00, 3'b001);
        step(5'b00100, 8'h00, 8'h00, 3'b011);
        repeat (20) @(posedge aclk);
        host.wr(TBS_ADDR_ACK, 32'h1, rs);
        rd_chk(TBS_ADDR_STATUS, exp_status(st, lk, 3'b011), TBS_RESP_OKAY);
        host.wr(TBS_ADDR_ACK, 32'h1 << TBS_BIT_ACK_FLAGS, rs);
        rd_chk(TBS_ADDR_STATUS, exp_status(st, lk, 3'b000), TBS_RESP_OKAY);
        st.fifo_direction = 1'b1;
        @(posedge aclk);
        mac_state <= st;
        step(5'b00100, 8'h00, 8'h00, 3'b000);
        step(5'b00010, 8'h00, 8'h00, 3'b010);
        step(5'b00001, 8'h80, 8'h7F, 3'b010);
        chk({tx_len_invalid, tx_payload_len}, 9'h07F, "255 byte request");
        step(5'b00001, 8'h80, 8'h80, 3'b110);
        chk({tx_len_invalid, tx_payload_len}, 9'h100, "256 byte request");
        for (int i = 0; i < 6; i++)
        begin
            h = $urandom;
            p = $urandom;
            step(5'b00001, h, p, 3'b110);
            chk({tx_len_invalid, tx_payload_len}, ({1'b0, h} + p >= TBS_LEN_LIMIT) ? 9'h100 : {1'b0, p}, "length");
        end
        host.wr(TBS_ADDR_ACK, 32'h2, rs);
        rd_chk(TBS_ADDR_STATUS, exp_status(st, lk, 3'b000), TBS_RESP_OKAY);
        $display("sticky flag test done");
        rd_chk(TBS_ADDR_ACK, 32'h0, TBS_RESP_OKAY);
        rd_chk(8'h40, 32'h0, TBS_RESP_DECERR);
        host.wr(8'h40, 32'hFFFF_FFFF, rs);
        chk({30'h0, rs}, {30'h0, TBS_RESP_DECERR}, "unmapped write response");
        rd_chk(TBS_ADDR_STATUS, exp_status(st, lk, 3'b000), TBS_RESP_OKAY);
        $display("address map test done");
        conclude();
    end
endmodule

// ==== verilog/tbs_status_regs.sv ====
// Status register bank for the token bus MAC, reached over AXI4-Lite.
// Assumes MAC state and event inputs are synchronous to aclk.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module tbs_status_regs
    import tbs_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [7:0] REVISION = 8'hA5 // Arbitrary value
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tbs_mac_state_t mac_state,
    input wire tbs_mac_event_t mac_event,
    output logic list_service_en,
    output logic rx_active,
    output logic tx_len_invalid,
    output logic [7:0] tx_payload_len
);
    // Refused at elaboration: the map needs four address bits and the bus carries 32
    if (ADDR_W < 4 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 4 and 32");
    end

    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_have_reg, w_have_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [31:0] status_reg;
    logic list_lock_reg;
    logic flag_clear;
    logic fifo_fault_reg, rx_overrun_reg, bad_len_reg;
    logic service_reg, rx_active_reg, tx_invalid_reg;
    logic [7:0] tx_len_reg;
    logic wr_fire;
    logic [8:0] req_sum;

    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    assign req_sum = {1'b0, mac_event.header_len} + {1'b0, mac_event.payload_len};
    // Only the flag clear bit matters; other acknowledge bits belong elsewhere
    assign flag_clear = wr_fire && waddr_reg == TBS_ADDR_ACK && wstrb_reg[0] && wdata_reg[TBS_BIT_ACK_FLAGS];

    // Write channel: address and data taken in either order, answer after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= TBS_RESP_OKAY;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_reg)
            begin
                awready_reg <= 1'b0;
                aw_have_reg <= 1'b1;
                waddr_reg <= 8'(s_axi_awaddr) & 8'hFC;
            end
            if (s_axi_wvalid && wready_reg)
            begin
                wready_reg <= 1'b0;
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                // Status writes are accepted and dropped
                if (waddr_reg == TBS_ADDR_STATUS || waddr_reg == TBS_ADDR_CTRL || waddr_reg == TBS_ADDR_ACK)
                    bresp_reg <= TBS_RESP_OKAY;
                else
                    bresp_reg <= TBS_RESP_DECERR;
            end
            if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, answer one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= TBS_RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= TBS_RESP_OKAY;
            unique case (8'(s_axi_araddr) & 8'hFC)
                TBS_ADDR_STATUS: rdata_reg <= status_reg;
                TBS_ADDR_CTRL: rdata_reg <= {31'h0000_0000, list_lock_reg};
                TBS_ADDR_ACK: rdata_reg <= 32'h0000_0000;
                default:
                begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= TBS_RESP_DECERR;
                end
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Request list lock, written by software
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            list_lock_reg <= TBS_LOCK_RESET;
        else if (wr_fire && waddr_reg == TBS_ADDR_CTRL && wstrb_reg[0])
            list_lock_reg <= wdata_reg[TBS_BIT_CTRL_LOCK];
    end

    // Lock only stops new list fetches; a block already running is not aborted
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            service_reg <= 1'b0;
            rx_active_reg <= 1'b0;
        end
        else
        begin
            service_reg <= !list_lock_reg;
            rx_active_reg <= mac_state.fifo_direction && mac_state.receiver_on;
        end
    end

    // Sticky error flags; a new event in the clearing cycle wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fifo_fault_reg <= 1'b0;
            rx_overrun_reg <= 1'b0;
            bad_len_reg <= 1'b0;
        end
        else
        begin
            if ((mac_event.fifo_underrun && !mac_state.fifo_direction)
                || (mac_event.fifo_overrun && mac_state.fifo_direction))
                fifo_fault_reg <= 1'b1;
            else if (flag_clear)
                fifo_fault_reg <= 1'b0;
            if (mac_event.new_frame && mac_event.transfer_busy)
                rx_overrun_reg <= 1'b1;
            else if (flag_clear)
                rx_overrun_reg <= 1'b0;
            if (mac_event.req_check && req_sum >= TBS_LEN_LIMIT)
                bad_len_reg <= 1'b1;
            else if (flag_clear)
                bad_len_reg <= 1'b0;
        end
    end

    // Transmit length for each checked request
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_invalid_reg <= 1'b0;
            tx_len_reg <= 8'h00;
        end
        else if (mac_event.req_check)
        begin
            tx_invalid_reg <= req_sum >= TBS_LEN_LIMIT;
            tx_len_reg <= (req_sum >= TBS_LEN_LIMIT) ? 8'h00 : mac_event.payload_len;
        end
    end

    // Live status snapshot, refreshed every cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status_reg <= TBS_STATUS_RESET;
        else
        begin
            status_reg <= TBS_STATUS_RESET;
            status_reg[TBS_BIT_OFFLINE] <= mac_state.offline;
            status_reg[TBS_BIT_LISTEN] <= mac_state.listen_token;
            status_reg[TBS_BIT_NOT_HOLD] <= mac_state.not_hold_token;
            status_reg[TBS_BIT_HOLD] <= mac_state.hold_token;
            status_reg[TBS_BIT_REQ_EMPTY] <= mac_state.req_empty;
            status_reg[TBS_BIT_BUS_LOCK] <= mac_state.bus_lock;
            status_reg[TBS_BIT_LIST_LOCK] <= list_lock_reg;
            status_reg[TBS_BIT_RX_ON] <= mac_state.receiver_on;
            status_reg[TBS_BIT_FIFO_DIR] <= mac_state.fifo_direction;
            // Shared memory mode forces zero
            status_reg[TBS_BIT_LOCK_WINNER] <= mac_state.dual_port_mode && mac_state.lock_conflict
                && mac_state.local_lock_first;
            status_reg[TBS_BIT_RING_POLL] <= mac_state.ring_poll_request_held;
            status_reg[TBS_BIT_CONF_IND] <= mac_state.conf_ind_held;
            status_reg[TBS_BIT_RX_OVERRUN] <= rx_overrun_reg;
            status_reg[TBS_BIT_FIFO_FAULT] <= fifo_fault_reg;
            status_reg[TBS_BIT_BAD_LEN] <= bad_len_reg;
            status_reg[TBS_BIT_TIMER_ROLE] <= mac_state.timer_role;
            status_reg[TBS_BIT_BLOCK_PRIO] <= mac_state.current_block_priority;
            status_reg[TBS_BIT_IDLE_LO +: 2] <= mac_state.idle_select;
            status_reg[TBS_BIT_STATION_LO +: 3] <= mac_state.station_kind;
            status_reg[TBS_BIT_REV_LO +: 8] <= REVISION;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign list_service_en = service_reg;
    assign rx_active = rx_active_reg;
    assign tx_len_invalid = tx_invalid_reg;
    assign tx_payload_len = tx_len_reg;

    property p_status_live;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> status_reg[TBS_BIT_HOLD] == $past(mac_state.hold_token)
            && status_reg[TBS_BIT_REV_LO +: 8] == REVISION;
    endproperty
    a_status_live: assert property (p_status_live) else $error("status word not live");

    property p_lock_service;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> list_service_en == !$past(list_lock_reg)
            && status_reg[TBS_BIT_LIST_LOCK] == $past(list_lock_reg);
    endproperty
    a_lock_service: assert property (p_lock_service) else $error("list service does not follow lock");

    property p_rx_bits;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> status_reg[TBS_BIT_RX_ON] == $past(mac_state.receiver_on)
            && status_reg[TBS_BIT_FIFO_DIR] == $past(mac_state.fifo_direction);
    endproperty
    a_rx_bits: assert property (p_rx_bits) else $error("receiver bits wrong");

    property p_rx_active;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> rx_active == (status_reg[TBS_BIT_RX_ON] && status_reg[TBS_BIT_FIFO_DIR]);
    endproperty
    a_rx_active: assert property (p_rx_active) else $error("receive activity wrong");

    property p_shared_winner;
        @(posedge aclk) disable iff (!aresetn)
        !mac_state.dual_port_mode ##1 1'b1 |-> !status_reg[TBS_BIT_LOCK_WINNER];
    endproperty
    a_shared_winner: assert property (p_shared_winner) else $error("lock winner set in shared mode");

    property p_overrun_set;
        @(posedge aclk) disable iff (!aresetn)
        mac_event.new_frame && mac_event.transfer_busy |-> ##2 status_reg[TBS_BIT_RX_OVERRUN];
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("frame overrun missed");

    property p_fault_tx;
        @(posedge aclk) disable iff (!aresetn)
        mac_event.fifo_underrun && !mac_state.fifo_direction |=> fifo_fault_reg;
    endproperty
    a_fault_tx: assert property (p_fault_tx) else $error("underrun not flagged");

    property p_fault_rx;
        @(posedge aclk) disable iff (!aresetn)
        mac_event.fifo_overrun && mac_state.fifo_direction |=> fifo_fault_reg;
    endproperty
    a_fault_rx: assert property (p_fault_rx) else $error("overrun not flagged");

    property p_sticky;
        @(posedge aclk) disable iff (!aresetn)
        bad_len_reg && !flag_clear |=> bad_len_reg;
    endproperty
    a_sticky: assert property (p_sticky) else $error("length flag dropped without clear");

    property p_bad_len;
        @(posedge aclk) disable iff (!aresetn)
        mac_event.req_check && req_sum >= TBS_LEN_LIMIT |=> bad_len_reg && tx_len_invalid
            && tx_payload_len == 8'h00;
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("invalid length not handled");
endmodule
